// ---- core/pfsd_pkg.sv ----
// Constants, register map and carrier types of the pin function select block
package pfsd_pkg;

  // ==========================================================================
  // Register indexes; byte address is four times the index
  // ==========================================================================
  localparam int unsigned NUM_REGS = 21;
  localparam int unsigned NUM_PINS = 26;
  localparam logic [4:0] IDX_SRC2  = 5'h00;
  localparam logic [4:0] IDX_SRC3  = 5'h01;
  localparam logic [4:0] IDX_PA_SINK = 5'h02;
  localparam logic [4:0] IDX_PD_SINK = 5'h03;
  localparam logic [4:0] IDX_PA_FN0  = 5'h04;
  localparam logic [4:0] IDX_PA_FN1  = 5'h05;
  localparam logic [4:0] IDX_PB_FN0  = 5'h06;
  localparam logic [4:0] IDX_PB_FN1  = 5'h07;
  localparam logic [4:0] IDX_PC_FN0  = 5'h08;
  localparam logic [4:0] IDX_PD_FN0  = 5'h09;
  localparam logic [4:0] IDX_PD_FN1  = 5'h0A;
  localparam logic [4:0] IDX_IN_SRC0 = 5'h0B;
  localparam logic [4:0] IDX_IN_SRC1 = 5'h0C;
  localparam logic [4:0] IDX_DATA_A = 5'h0D;
  localparam logic [4:0] IDX_DATA_B = 5'h0E;
  localparam logic [4:0] IDX_DATA_C = 5'h0F;
  localparam logic [4:0] IDX_DATA_D = 5'h10;
  localparam logic [4:0] IDX_DIR_A = 5'h11;
  localparam logic [4:0] IDX_DIR_B = 5'h12;
  localparam logic [4:0] IDX_DIR_C = 5'h13;
  localparam logic [4:0] IDX_DIR_D = 5'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned SRC2_PD_LSB = 3;
  localparam int unsigned SRC2_PC_LSB = 0;
  localparam int unsigned SRC3_PD_LSB = 0;
  localparam int unsigned PORT_B_BASE = 8;
  localparam int unsigned PORT_C_BASE = 16;
  localparam int unsigned PORT_D_BASE = 18;

  // ==========================================================================
  // Implemented bits and reset values
  // ==========================================================================
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'h3F, 8'h07, 8'h35, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF,
    8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF};
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h12, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF};

  // ==========================================================================
  // Pin sources and carriers
  // ==========================================================================
  typedef enum logic [4:0] {
    SRC_GPIO  = 5'h00,
    SRC_CT_OUT0 = 5'h01,
    SRC_CT_OUT1 = 5'h02,
    SRC_CT_OUT2 = 5'h03,
    SRC_CT_OUT3 = 5'h04,
    SRC_CT_INV0 = 5'h05,
    SRC_CT_INV1 = 5'h06,
    SRC_CT_INV2 = 5'h07,
    SRC_CT_INV3 = 5'h08,
    SRC_PT_OUT  = 5'h09,
    SRC_PT_INV  = 5'h0A,
    SRC_SDA   = 5'h0B,
    SRC_SCL   = 5'h0C,
    SRC_TX    = 5'h0D,
    SRC_RXTX  = 5'h0E,
    SRC_KEY   = 5'h0F,
    SRC_XT    = 5'h10
  } pfsd_src_t;

  typedef struct packed {
    logic [3:0] compact_timer_out;
    logic       periodic_timer_out;
    logic       sda_o;
    logic       sda_oe_n;
    logic       scl_o;
    logic       scl_oe_n;
    logic       tx;
    logic       rxtx_o;
    logic       rxtx_oe_n;
  } pfsd_perif_t;

  typedef struct packed {
    logic [2:0] src_pc;
    logic [2:0] src_pd_lo;
    logic [2:0] src_pd_hi;
    logic [7:0] sink_pa;
    logic [7:0] sink_pd;
  } pfsd_drive_t;

endpackage

// ---- core/pfsd_top.sv ----
// Pin function select, drive strength registers and pin multiplexer
// Behaviour
// - src_current_sel_2[5:3] sets port D 3..0 level
// - src_current_sel_2[2:0] sets port C 1..0 level
// - src_current_sel_3[2:0] sets port D 7..4 level
// - src_current_sel_3 upper five bits unimplemented
// - Sink bit acts only on CMOS outputs
// - porta_sink_sel holds bits 5,4,2,0 only
// - portd_sink_sel holds bits 7..2 only
// - Port A pin 3 routing codes
// - Port A pin 2 routing codes
// - Port A pin 1 routing codes
// - Port A pin 0 routing codes
// - Port A pin 7 routing codes
// - Port A pin 6 routing codes
// - Port A pin 5 routing codes
// - Port A pin 4 routing codes
// - Port B pins 3..0 touch key or I/O
// - Port B pins 7..4 key, timer, inverted timer
// - Port C pin 1 routing, upper bits read 0
// - Port C pin 0 routing codes
// - Direction bit 1 input, 0 CMOS output
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module pfsd_top (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire pfsd_pkg::pfsd_perif_t perif_i,
  input  wire logic [25:0]          pad_in,
  output logic      [25:0]          pad_out,
  output logic      [25:0]          pad_oe_n,
  output pfsd_pkg::pfsd_drive_t     drive_o,
  output logic      [11:0]          touch_key_en,
  output logic      [1:0]           low_xtal_en
);

  // ==========================================================================
  // Source decode per pin
  // ==========================================================================
  function automatic pfsd_pkg::pfsd_src_t route_of(input int unsigned pin,
                                                   input logic [1:0] code);
    pfsd_pkg::pfsd_src_t s;
    s = pfsd_pkg::SRC_GPIO;
    case (pin)
      0: case (code)
        2'h1: s = pfsd_pkg::SRC_CT_INV0;
        2'h2: s = pfsd_pkg::SRC_CT_OUT1;
        2'h3: s = pfsd_pkg::SRC_CT_INV3;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      1: case (code)
        2'h1: s = pfsd_pkg::SRC_SCL;
        2'h2: s = pfsd_pkg::SRC_RXTX;
        2'h3: s = pfsd_pkg::SRC_XT;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      2: case (code)
        2'h1: s = pfsd_pkg::SRC_PT_INV;
        2'h2: s = pfsd_pkg::SRC_CT_INV1;
        2'h3: s = pfsd_pkg::SRC_CT_OUT2;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      3: case (code)
        2'h1: s = pfsd_pkg::SRC_SDA;
        2'h2: s = pfsd_pkg::SRC_TX;
        2'h3: s = pfsd_pkg::SRC_XT;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      4: case (code)
        2'h1: s = pfsd_pkg::SRC_CT_OUT0;
        2'h2: s = pfsd_pkg::SRC_CT_INV2;
        2'h3: s = pfsd_pkg::SRC_PT_OUT;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      5: case (code)
        2'h1: s = pfsd_pkg::SRC_CT_INV0;
        2'h2: s = pfsd_pkg::SRC_CT_OUT3;
        2'h3: s = pfsd_pkg::SRC_PT_INV;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      6: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_SCL;
        2'h3: s = pfsd_pkg::SRC_RXTX;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      7: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_SDA;
        2'h3: s = pfsd_pkg::SRC_TX;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      8, 9, 10, 11: s = (code == 2'h1) ? pfsd_pkg::SRC_KEY : pfsd_pkg::SRC_GPIO;
      12: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_CT_OUT3;
        2'h3: s = pfsd_pkg::SRC_CT_INV0;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      13: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_CT_OUT2;
        2'h3: s = pfsd_pkg::SRC_CT_INV1;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      14: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_CT_OUT1;
        2'h3: s = pfsd_pkg::SRC_CT_INV2;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      15: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_CT_OUT0;
        2'h3: s = pfsd_pkg::SRC_CT_INV3;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      16: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_CT_OUT1;
        2'h3: s = pfsd_pkg::SRC_CT_OUT3;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      17: case (code)
        2'h1: s = pfsd_pkg::SRC_KEY;
        2'h2: s = pfsd_pkg::SRC_CT_OUT0;
        2'h3: s = pfsd_pkg::SRC_CT_OUT2;
        default: s = pfsd_pkg::SRC_GPIO;
      endcase
      default: s = pfsd_pkg::SRC_GPIO;
    endcase
    return s;
  endfunction

  // ==========================================================================
  // Register file over Wishbone
  // ==========================================================================
  logic [7:0]  regs_reg [pfsd_pkg::NUM_REGS];
  logic [25:0] pin_in_reg;
  logic [4:0]  bus_idx;
  logic        bus_hit;
  logic        bus_req;
  logic [7:0]  rd_byte;

  assign bus_idx = wb_adr_i[6:2];
  assign bus_hit = (wb_adr_i[7] == 1'b0) && (wb_adr_i[1:0] == 2'h0) &&
                   (bus_idx < 5'(pfsd_pkg::NUM_REGS));
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Writes land at the ack edge; unimplemented bits never stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < pfsd_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= pfsd_pkg::REG_RESET[i];
      end
    end else if (bus_req && wb_we_i && wb_sel_i[0] && bus_hit) begin
      regs_reg[bus_idx] <= wb_dat_i[7:0] & pfsd_pkg::REG_MASK[bus_idx];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_in_reg <= 26'h0000000;
    end else begin
      pin_in_reg <= pad_in;
    end
  end

  // Data registers read the pin when input, the latch when output
  always_comb begin
    rd_byte = 8'h00;
    if (bus_hit) begin
      case (bus_idx)
        pfsd_pkg::IDX_DATA_A: rd_byte = (regs_reg[bus_idx] & ~regs_reg[pfsd_pkg::IDX_DIR_A]) |
                                        (pin_in_reg[7:0] & regs_reg[pfsd_pkg::IDX_DIR_A]);
        pfsd_pkg::IDX_DATA_B: rd_byte = (regs_reg[bus_idx] & ~regs_reg[pfsd_pkg::IDX_DIR_B]) |
                                        (pin_in_reg[15:8] & regs_reg[pfsd_pkg::IDX_DIR_B]);
        pfsd_pkg::IDX_DATA_C: rd_byte = (regs_reg[bus_idx] & ~regs_reg[pfsd_pkg::IDX_DIR_C]) |
                                        ({6'h00, pin_in_reg[17:16]} &
                                         regs_reg[pfsd_pkg::IDX_DIR_C]);
        pfsd_pkg::IDX_DATA_D: rd_byte = (regs_reg[bus_idx] & ~regs_reg[pfsd_pkg::IDX_DIR_D]) |
                                        (pin_in_reg[25:18] & regs_reg[pfsd_pkg::IDX_DIR_D]);
        default:              rd_byte = regs_reg[bus_idx];
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // ==========================================================================
  // Pin multiplexer
  // ==========================================================================
  logic [25:0] latch_all;
  logic [25:0] dir_all;
  logic [25:0] out_next;
  logic [25:0] drv_next;
  pfsd_pkg::pfsd_src_t src_of [pfsd_pkg::NUM_PINS];

  assign latch_all = {regs_reg[pfsd_pkg::IDX_DATA_D], regs_reg[pfsd_pkg::IDX_DATA_C][1:0],
                      regs_reg[pfsd_pkg::IDX_DATA_B], regs_reg[pfsd_pkg::IDX_DATA_A]};
  assign dir_all   = {regs_reg[pfsd_pkg::IDX_DIR_D], regs_reg[pfsd_pkg::IDX_DIR_C][1:0],
                      regs_reg[pfsd_pkg::IDX_DIR_B], regs_reg[pfsd_pkg::IDX_DIR_A]};

  for (genvar gi = 0; gi < pfsd_pkg::NUM_PINS; gi++) begin : g_pin
    logic [1:0] code;
    if (gi < 4) begin : g_a0
      assign code = regs_reg[pfsd_pkg::IDX_PA_FN0][2*gi +: 2];
    end else if (gi < 8) begin : g_a1
      assign code = regs_reg[pfsd_pkg::IDX_PA_FN1][2*(gi-4) +: 2];
    end else if (gi < 12) begin : g_b0
      assign code = regs_reg[pfsd_pkg::IDX_PB_FN0][2*(gi-8) +: 2];
    end else if (gi < 16) begin : g_b1
      assign code = regs_reg[pfsd_pkg::IDX_PB_FN1][2*(gi-12) +: 2];
    end else if (gi < 18) begin : g_c
      assign code = regs_reg[pfsd_pkg::IDX_PC_FN0][2*(gi-16) +: 2];
    end else begin : g_d
      // Port D function registers are not decoded; pins stay on the latch here
      assign code = 2'h0;
    end
    assign src_of[gi] = route_of(gi, code);

    always_comb begin
      out_next[gi] = 1'b0;
      drv_next[gi] = 1'b1;
      case (src_of[gi])
        pfsd_pkg::SRC_GPIO: begin
          out_next[gi] = latch_all[gi];
          drv_next[gi] = !dir_all[gi];
        end
        pfsd_pkg::SRC_CT_OUT0: out_next[gi] = perif_i.compact_timer_out[0];
        pfsd_pkg::SRC_CT_OUT1: out_next[gi] = perif_i.compact_timer_out[1];
        pfsd_pkg::SRC_CT_OUT2: out_next[gi] = perif_i.compact_timer_out[2];
        pfsd_pkg::SRC_CT_OUT3: out_next[gi] = perif_i.compact_timer_out[3];
        pfsd_pkg::SRC_CT_INV0: out_next[gi] = !perif_i.compact_timer_out[0];
        pfsd_pkg::SRC_CT_INV1: out_next[gi] = !perif_i.compact_timer_out[1];
        pfsd_pkg::SRC_CT_INV2: out_next[gi] = !perif_i.compact_timer_out[2];
        pfsd_pkg::SRC_CT_INV3: out_next[gi] = !perif_i.compact_timer_out[3];
        pfsd_pkg::SRC_PT_OUT:  out_next[gi] = perif_i.periodic_timer_out;
        pfsd_pkg::SRC_PT_INV:  out_next[gi] = !perif_i.periodic_timer_out;
        pfsd_pkg::SRC_TX:    out_next[gi] = perif_i.tx;
        pfsd_pkg::SRC_SDA: begin
          out_next[gi] = perif_i.sda_o;
          drv_next[gi] = !perif_i.sda_oe_n;
        end
        pfsd_pkg::SRC_SCL: begin
          out_next[gi] = perif_i.scl_o;
          drv_next[gi] = !perif_i.scl_oe_n;
        end
        pfsd_pkg::SRC_RXTX: begin
          out_next[gi] = perif_i.rxtx_o;
          drv_next[gi] = !perif_i.rxtx_oe_n;
        end
        default:             drv_next[gi] = 1'b0;       // Touch key and crystal: analog
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out  <= 26'h0000000;
      pad_oe_n <= 26'h3FFFFFF;
    end else begin
      pad_out  <= out_next;
      pad_oe_n <= ~drv_next;
    end
  end

  // ==========================================================================
  // Analog function enables
  // ==========================================================================
  logic [11:0] key_next;
  logic [1:0]  xt_next;

  for (genvar gk = 0; gk < 8; gk++) begin : g_keyb
    assign key_next[gk] = (src_of[pfsd_pkg::PORT_B_BASE + gk] == pfsd_pkg::SRC_KEY);
  end
  assign key_next[8]  = (src_of[pfsd_pkg::PORT_C_BASE] == pfsd_pkg::SRC_KEY);
  assign key_next[9]  = (src_of[pfsd_pkg::PORT_C_BASE + 1] == pfsd_pkg::SRC_KEY);
  assign key_next[10] = (src_of[6] == pfsd_pkg::SRC_KEY);
  assign key_next[11] = (src_of[7] == pfsd_pkg::SRC_KEY);
  assign xt_next      = {src_of[3] == pfsd_pkg::SRC_XT, src_of[1] == pfsd_pkg::SRC_XT};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_key_en <= 12'h000;
      low_xtal_en  <= 2'h0;
    end else begin
      touch_key_en <= key_next;
      low_xtal_en  <= xt_next;
    end
  end

  // ==========================================================================
  // Drive strength outputs
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_o <= '0;
    end else begin
      drive_o.src_pd_lo <= regs_reg[pfsd_pkg::IDX_SRC2][pfsd_pkg::SRC2_PD_LSB +: 3];
      drive_o.src_pc    <= regs_reg[pfsd_pkg::IDX_SRC2][pfsd_pkg::SRC2_PC_LSB +: 3];
      drive_o.src_pd_hi <= regs_reg[pfsd_pkg::IDX_SRC3][pfsd_pkg::SRC3_PD_LSB +: 3];
      drive_o.sink_pa   <= regs_reg[pfsd_pkg::IDX_PA_SINK] & drv_next[7:0];
      drive_o.sink_pd   <= regs_reg[pfsd_pkg::IDX_PD_SINK] &
                           drv_next[pfsd_pkg::PORT_D_BASE +: 8];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_write(logic [4:0] idx);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && bus_hit && bus_idx == idx;
  endsequence

  a_src2_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write(pfsd_pkg::IDX_SRC2) |=> ##1 drive_o.src_pd_lo == $past(wb_dat_i[5:3], 2))
    else $error("port D low drive level not taken from write");
  a_src2_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write(pfsd_pkg::IDX_SRC2) |=> ##1 drive_o.src_pc == $past(wb_dat_i[2:0], 2))
    else $error("port C drive level not taken from write");
  a_src3_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o && !$past(wb_we_i) && $past(bus_idx) == pfsd_pkg::IDX_SRC3 && $past(bus_hit)
    |-> wb_dat_o[31:3] == 29'h0 && wb_dat_o[2:0] == drive_o.src_pd_hi)
    else $error("source select 3 read wrong");
  a_sink_cmos: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pad_oe_n[7:0] & drive_o.sink_pa) == 8'h00 &&
    (pad_oe_n[25:18] & drive_o.sink_pd) == 8'h00)
    else $error("sink level active on a pin that is not driven");
  a_sink_masks: assert property (@(posedge core_clk) disable iff (!rst_n)
    (regs_reg[pfsd_pkg::IDX_PA_SINK] & 8'hCA) == 8'h00 &&
    regs_reg[pfsd_pkg::IDX_PD_SINK][1:0] == 2'h0)
    else $error("unimplemented sink bit stored");
  a_pa3_sda: assert property (@(posedge core_clk) disable iff (!rst_n)
    regs_reg[pfsd_pkg::IDX_PA_FN0][7:6] == 2'h1 |=>
    pad_out[3] == $past(perif_i.sda_o) && pad_oe_n[3] == $past(perif_i.sda_oe_n))
    else $error("port A pin 3 not following data line");
  a_pa0_ctpb: assert property (@(posedge core_clk) disable iff (!rst_n)
    regs_reg[pfsd_pkg::IDX_PA_FN0][1:0] == 2'h1 |=>
    pad_out[0] == !$past(perif_i.compact_timer_out[0]) && !pad_oe_n[0])
    else $error("port A pin 0 not inverted timer 0");
  a_pb_key: assert property (@(posedge core_clk) disable iff (!rst_n)
    regs_reg[pfsd_pkg::IDX_PB_FN0][1:0] == 2'h1 |=> touch_key_en[0] && pad_oe_n[8])
    else $error("port B pin 0 touch key not enabled");
  a_gpio_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n && src_of[4] == pfsd_pkg::SRC_GPIO |=>
    pad_oe_n[4] == $past(dir_all[4]) && pad_out[4] == $past(latch_all[4]))
    else $error("general I/O pin not following latch and direction");
  a_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

endmodule // pfsd_top

`default_nettype wire

// ---- testbench/pfsd_perif_model.sv ----
// Peripheral and pad model on the far side of the pin multiplexer
`timescale 1ns/10ps
`default_nettype none

module pfsd_perif_model (
  input  wire logic             perif_en,
  output var pfsd_pkg::pfsd_perif_t perif_o,
  input  wire logic [25:0]      pad_out,
  input  wire logic [25:0]      pad_oe_n,
  output logic      [25:0]      pad_in
);
  // ==========================================================================
  // Peripheral outputs, idle until enabled after selection
  // ==========================================================================
  assign perif_o = perif_en ?
    pfsd_pkg::pfsd_perif_t'{compact_timer_out: 4'h6, periodic_timer_out: 1'b1, sda_o: 1'b0,
      sda_oe_n: 1'b0, scl_o: 1'b1, scl_oe_n: 1'b0, tx: 1'b1, rxtx_o: 1'b0, rxtx_oe_n: 1'b0} :
    pfsd_pkg::pfsd_perif_t'{compact_timer_out: 4'h0, periodic_timer_out: 1'b0, sda_o: 1'b0,
      sda_oe_n: 1'b1, scl_o: 1'b0, scl_oe_n: 1'b1, tx: 1'b0, rxtx_o: 1'b0, rxtx_oe_n: 1'b1};
  // Released pins pulled high
  assign pad_in = (pad_out & ~pad_oe_n) | pad_oe_n;
endmodule // pfsd_perif_model

`default_nettype wire

// ---- testbench/pfsd_top_tb.sv ----
// Self-checking testbench of the pin function select block
`timescale 1ns/10ps
`default_nettype none

module pfsd_top_tb;
  logic                  core_clk = 1'b0;
  logic                  rst_n    = 1'b0;
  logic                  cyc      = 1'b0;
  logic                  stb      = 1'b0;
  logic                  we       = 1'b0;
  logic [7:0]            adr      = 8'h00;
  logic [3:0]            sel      = 4'h1;
  logic [31:0]           dat_i    = 32'h0;
  logic                  perif_en = 1'b0;
  logic [31:0]           dat_o;
  logic                  ack;
  logic [25:0]           pad_in;
  logic [25:0]           pad_out;
  logic [25:0]           pad_oe_n;
  logic [11:0]           keys;
  logic [1:0]            xtal;
  logic [7:0]            q;
  pfsd_pkg::pfsd_perif_t perif;
  pfsd_pkg::pfsd_drive_t drv;
  int                    bad_count = 0;
  int                    compares  = 0;
  int                    cycles    = 0;

  always #10 core_clk = ~core_clk;

  pfsd_top dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .perif_i(perif), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .drive_o(drv), .touch_key_en(keys), .low_xtal_en(xtal));
  pfsd_perif_model partner (.perif_en(perif_en), .perif_o(perif), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_in(pad_in));

  // ==========================================================================
  // Bus, compare and closing tasks
  // ==========================================================================
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_levels;
    @(posedge core_clk);
    chk(drv.src_pd_lo, 2);
    chk(drv.src_pc, 2);
    chk(drv.src_pd_hi, 2);
    wb(0, 8'h00, 0); chk(q, 8'h12);
    wb(1, 8'h00, 8'h3D); wb(1, 8'h04, 8'hFF); wb(0, 8'h04, 0); chk(q, 8'h07);
    settle;
    chk(drv.src_pd_lo, 7);
    chk(drv.src_pc, 5);
    chk(drv.src_pd_hi, 7);
    $display("levels done");
  endtask

  task automatic t_sink;
    wb(1, 8'h44, 0); wb(1, 8'h08, 8'hFF); wb(0, 8'h08, 0); chk(q, 8'h35);
    settle; chk(drv.sink_pa, 8'h35);
    wb(1, 8'h44, 8'hFF); settle; chk(drv.sink_pa, 0);
    wb(1, 8'h0C, 8'hFF); wb(0, 8'h0C, 0); chk(q, 8'hFC);
    wb(1, 8'h50, 0); settle; chk(drv.sink_pd, 8'hFC);
    $display("sink done");
  endtask

  task automatic t_route;
    logic [3:0] exp0;
    logic [2:0] exp3;
    exp0 = 4'hE;
    exp3 = 3'h4;
    wb(1, 8'h44, 0); wb(1, 8'h34, 0);
    for (int c = 0; c < 4; c++) begin
      perif_en <= 1'b0;
      wb(1, 8'h10, {c[1:0], 4'h0, c[1:0]});
      perif_en <= 1'b1;
      settle;
      chk(pad_out[0], exp0[c]);
      if (c < 3) chk({pad_oe_n[3], pad_out[3]}, {1'b0, exp3[c]});
      chk({pad_oe_n[3], xtal[1]}, {2{c == 3}});
    end
    perif_en <= 1'b0;
    wb(1, 8'h10, 0);
    wb(1, 8'h14, 0); wb(1, 8'h44, 8'h10); settle;
    chk(pad_oe_n[4], 1'b1);
    wb(0, 8'h34, 0); chk(q, 8'h10);
    $display("route done");
  endtask

  task automatic t_keys;
    wb(1, 8'h18, 8'h55); settle; chk(keys[3:0], 4'hF);
    wb(1, 8'h18, 8'hAA); settle; chk(keys[3:0], 4'h0);
    wb(1, 8'h1C, 8'hDA); perif_en <= 1'b1; settle;
    chk(pad_out[15:12], 4'hA);
    chk(pad_oe_n[15:12], 4'h4);
    chk(keys[7:4], 4'h4);
    perif_en <= 1'b0; wb(1, 8'h1C, 0);
    wb(1, 8'h20, 8'hFF); wb(0, 8'h20, 0); chk(q, 8'h0F);
    wb(1, 8'h54, 8'hA5); wb(0, 8'h54, 0); chk(q, 8'h00);
    $display("keys done");
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  // ==========================================================================
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_levels();
    t_sink();
    t_route();
    t_keys();
    summarize();
  end
endmodule // pfsd_top_tb

`default_nettype wire
